// ### hdl/io_crossbar.sv
/*
  Priority pin crossbar for the seven port-zero pins of the small package.
  Routes pins to GPIO by default and to on-chip blocks when they are enabled and granted by priority.
  Assumes all inputs are synchronous to clk_sys_i and that pad buffers and
  analog switches outside act on the registered controls.
*/
`timescale 1ns/1ps
`include "io_crossbar_regs.svh"

module io_crossbar #(
  parameter logic [2:0] ADC_REF_PIN = 3'h2
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [6:0] port_data_reg_i,
  input wire logic [6:0] pin_direction_reg_i,
  input wire io_crossbar_pkg::feature_t [6:0] pin_feature_reg_i,
  input wire logic [6:0] pad_in_i,
  input wire logic uart_txd_i,
  input wire logic slow_crystal_osc_en_i,
  input wire logic [2:0] low_freq_clock_cfg_i,
  input wire logic spi_master_en_i,
  input wire logic master_data_out_i,
  input wire logic master_serial_clock_i,
  input wire logic spi_slave_en_i,
  input wire logic program_enable_i,
  input wire logic slave_data_out_i,
  input wire logic debug_en_i,
  input wire logic debug_aux_out_i,
  input wire logic debug_data_out_i,
  input wire logic two_wire_en_i,
  input wire logic two_wire_data_out_i,
  input wire logic two_wire_data_oe_i,
  input wire logic two_wire_clock_out_i,
  input wire logic two_wire_clock_oe_i,
  input wire logic pwm_en_i,
  input wire logic pulse_out_a_i,
  input wire logic pulse_out_b_i,
  input wire logic adc_en_i,
  input wire logic comparator_en_i,
  input wire logic [3:0] adc_channel_select_i,
  input wire logic adc_reference_select_i,
  output io_crossbar_pkg::pad_ctrl_t pad_o,
  output io_crossbar_pkg::feature_t [6:0] pad_feature_o,
  output io_crossbar_pkg::periph_in_t periph_o,
  output logic [6:0] port_data_in_o,
  output logic [5:0] grant_o
);

  // Pin number to one-hot pin mask, zero beyond the last pin
  function automatic logic [6:0] pin_onehot(input logic [3:0] idx);
    pin_onehot = `MASK_NONE;
    if (idx <= `ADC_LAST_PIN_CHANNEL) begin
      pin_onehot[idx[2:0]] = 1'b1;
    end
  endfunction

  logic [5:0] req_en;
  logic [6:0] req_mask [6];
  logic [5:0] grant;
  logic [6:0] xosc_ana;
  logic [6:0] adc_want;
  logic [6:0] adc_ana;
  logic [6:0] in_en;
  io_crossbar_pkg::pad_ctrl_t pad_nxt;
  io_crossbar_pkg::feature_t [6:0] feat_nxt;
  io_crossbar_pkg::periph_in_t periph_nxt;
  logic [6:0] data_in_nxt;

  // Oscillator asks for analog or digital pins per its source field
  always_comb begin
    xosc_ana = `MASK_NONE;
    if (slow_crystal_osc_en_i && low_freq_clock_cfg_i == `LFCLK_CRYSTAL) begin
      xosc_ana = `MASK_XOSC_XTAL;
    end else if (slow_crystal_osc_en_i && low_freq_clock_cfg_i == `LFCLK_LOW_AMP) begin
      xosc_ana = `MASK_XOSC_LOWAMP;
    end
  end

  // Digital requests; the slave set also serves flash loading
  always_comb begin
    req_en[`REQ_XOSC] = slow_crystal_osc_en_i && low_freq_clock_cfg_i == `LFCLK_DIGITAL;
    req_en[`REQ_MASTER] = spi_master_en_i;
    req_en[`REQ_SLAVE] = spi_slave_en_i || program_enable_i;
    req_en[`REQ_DEBUG] = debug_en_i;
    req_en[`REQ_TWO_WIRE] = two_wire_en_i;
    req_en[`REQ_PWM] = pwm_en_i;
    req_mask[`REQ_XOSC] = `MASK_XOSC_DIG;
    req_mask[`REQ_MASTER] = `MASK_MASTER;
    req_mask[`REQ_SLAVE] = `MASK_SLAVE;
    req_mask[`REQ_DEBUG] = `MASK_DEBUG;
    req_mask[`REQ_TWO_WIRE] = `MASK_TWO_WIRE;
    req_mask[`REQ_PWM] = `MASK_PWM;
  end

  // Any enabled higher block touching one pin denies the whole set
  for (genvar k = 0; k < `XBAR_NUM_DIG; k++) begin : g_grant
    logic [6:0] higher;
    always_comb begin
      higher = `MASK_NONE;
      for (int j = 0; j < k; j++) begin
        if (req_en[j]) begin
          higher = higher | req_mask[j];
        end
      end
      higher = higher | ((k > 0) ? xosc_ana : `MASK_NONE);
      grant[k] = req_en[k] && ((higher & req_mask[k]) == `MASK_NONE);
    end
  end

  // Converter and comparator share one analog column and its selects
  always_comb begin
    adc_want = `MASK_NONE;
    if (adc_en_i || comparator_en_i) begin
      adc_want = pin_onehot(adc_channel_select_i);
      if (adc_reference_select_i) begin
        adc_want = adc_want | pin_onehot({1'b0, ADC_REF_PIN});
      end
    end
    adc_ana = adc_want & ~xosc_ana;
  end

  // Direction register bit set means output
  assign in_en = ~pin_direction_reg_i;

  // Pad drive: GPIO first, granted blocks override their own pins only
  always_comb begin
    pad_nxt.out = port_data_reg_i;
    pad_nxt.out[`PIN_SEL] = port_data_reg_i[`PIN_SEL] & uart_txd_i;
    pad_nxt.oe = pin_direction_reg_i;
    feat_nxt = pin_feature_reg_i;
    // Analog switches never touch the digital settings
    pad_nxt.analog_adc = adc_ana;
    pad_nxt.analog_xosc = xosc_ana;
    if (grant[`REQ_PWM]) begin
      pad_nxt.out[`PIN_MOSI] = pulse_out_a_i;
      pad_nxt.oe[`PIN_MOSI] = 1'b1;
      feat_nxt[`PIN_MOSI] = `FEAT_OUT_NORMAL;
      pad_nxt.out[`PIN_AUX] = pulse_out_b_i;
      pad_nxt.oe[`PIN_AUX] = 1'b1;
      feat_nxt[`PIN_AUX] = `FEAT_OUT_NORMAL;
    end
    if (grant[`REQ_TWO_WIRE]) begin
      pad_nxt.out[`PIN_AUX] = two_wire_data_out_i;
      pad_nxt.oe[`PIN_AUX] = two_wire_data_oe_i;
      feat_nxt[`PIN_AUX] = `FEAT_IN_NOPULL;
      pad_nxt.out[`PIN_SEL] = two_wire_clock_out_i;
      pad_nxt.oe[`PIN_SEL] = two_wire_clock_oe_i;
      feat_nxt[`PIN_SEL] = `FEAT_IN_NOPULL;
    end
    if (grant[`REQ_DEBUG]) begin
      pad_nxt.out[`PIN_AUX] = debug_aux_out_i;
      pad_nxt.oe[`PIN_AUX] = 1'b1;
      feat_nxt[`PIN_AUX] = `FEAT_OUT_NORMAL;
      pad_nxt.out[`PIN_SEL] = debug_data_out_i;
      pad_nxt.oe[`PIN_SEL] = 1'b1;
      feat_nxt[`PIN_SEL] = `FEAT_OUT_NORMAL;
      pad_nxt.oe[`PIN_MISO] = 1'b0;
      pad_nxt.oe[`PIN_MOSI] = 1'b0;
      pad_nxt.oe[`PIN_SCLK] = 1'b0;
      feat_nxt[`PIN_MISO] = `FEAT_IN_NOPULL;
      feat_nxt[`PIN_MOSI] = `FEAT_IN_NOPULL;
      feat_nxt[`PIN_SCLK] = `FEAT_IN_NOPULL;
    end
    if (grant[`REQ_SLAVE]) begin
      pad_nxt.oe[`PIN_SEL] = 1'b0;
      feat_nxt[`PIN_SEL] = `FEAT_IN_NOPULL;
      // Shared data-out line must float while unselected
      pad_nxt.out[`PIN_MISO] = slave_data_out_i;
      pad_nxt.oe[`PIN_MISO] = ~pad_in_i[`PIN_SEL];
      feat_nxt[`PIN_MISO] = `FEAT_OUT_NORMAL;
      pad_nxt.oe[`PIN_MOSI] = 1'b0;
      pad_nxt.oe[`PIN_SCLK] = 1'b0;
      feat_nxt[`PIN_MOSI] = `FEAT_IN_NOPULL;
      feat_nxt[`PIN_SCLK] = `FEAT_IN_NOPULL;
    end
    if (grant[`REQ_MASTER]) begin
      pad_nxt.oe[`PIN_MISO] = 1'b0;
      feat_nxt[`PIN_MISO] = `FEAT_IN_NOPULL;
      pad_nxt.out[`PIN_MOSI] = master_data_out_i;
      pad_nxt.oe[`PIN_MOSI] = 1'b1;
      feat_nxt[`PIN_MOSI] = `FEAT_OUT_NORMAL;
      pad_nxt.out[`PIN_SCLK] = master_serial_clock_i;
      pad_nxt.oe[`PIN_SCLK] = 1'b1;
      feat_nxt[`PIN_SCLK] = `FEAT_OUT_NORMAL;
    end
    if (grant[`REQ_XOSC]) begin
      pad_nxt.oe[`PIN_XTAL_B] = 1'b0;
      feat_nxt[`PIN_XTAL_B] = `FEAT_IN_NOPULL;
    end
  end

  // Levels handed inward; idle values keep denied blocks quiet
  always_comb begin
    periph_nxt.master_data_in = grant[`REQ_MASTER] & pad_in_i[`PIN_MISO];
    periph_nxt.slave_select_n = grant[`REQ_SLAVE] ? pad_in_i[`PIN_SEL] : 1'b1;
    periph_nxt.slave_data_in = grant[`REQ_SLAVE] & pad_in_i[`PIN_MOSI];
    periph_nxt.slave_serial_clock = grant[`REQ_SLAVE] & pad_in_i[`PIN_SCLK];
    periph_nxt.debug_data_in = grant[`REQ_DEBUG] & pad_in_i[`PIN_MISO];
    periph_nxt.debug_mode_select = grant[`REQ_DEBUG] & pad_in_i[`PIN_MOSI];
    periph_nxt.debug_test_clock = grant[`REQ_DEBUG] & pad_in_i[`PIN_SCLK];
    // Two-wire lines idle high when not owned
    periph_nxt.two_wire_data = grant[`REQ_TWO_WIRE] ? pad_in_i[`PIN_AUX] : 1'b1;
    periph_nxt.two_wire_clock = grant[`REQ_TWO_WIRE] ? pad_in_i[`PIN_SEL] : 1'b1;
    periph_nxt.low_freq_clock = grant[`REQ_XOSC] & pad_in_i[`PIN_XTAL_B];
    // Receiver idles high when its pin is not an input
    periph_nxt.uart_rxd = pad_in_i[`PIN_AUX] | ~in_en[`PIN_AUX];
    periph_nxt.ext_int0 = pad_in_i[`PIN_XTAL_A] & in_en[`PIN_XTAL_A];
    periph_nxt.ext_int1 = pad_in_i[`PIN_SCLK] & in_en[`PIN_SCLK];
    periph_nxt.timer0_in = pad_in_i[`PIN_MISO] & in_en[`PIN_MISO];
    data_in_nxt = pad_in_i & in_en;
  end

  // Pad controls; reset leaves every pin a plain digital input
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      pad_o <= '0;
      for (int p = 0; p < `XBAR_NUM_PINS; p++) begin
        pad_feature_o[p] <= `FEAT_IN_NOPULL;
      end
    end else begin
      pad_o <= pad_nxt;
      pad_feature_o <= feat_nxt;
    end
  end

  // Inward levels and grant status; re-evaluated every cycle
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      periph_o <= '0;
      periph_o.slave_select_n <= 1'b1;
      periph_o.two_wire_data <= 1'b1;
      periph_o.two_wire_clock <= 1'b1;
      periph_o.uart_rxd <= 1'b1;
      port_data_in_o <= '0;
      grant_o <= '0;
    end else begin
      periph_o <= periph_nxt;
      port_data_in_o <= data_in_nxt;
      grant_o <= grant;
    end
  end

  AST_RESET_INPUT: assert property (@(posedge clk_sys_i)
    reset_i |-> (pad_o.oe == '0 && pad_o.analog_adc == '0 && pad_feature_o[0] == `FEAT_IN_NOPULL))
    else $error("pins not inputs during reset");

  AST_MASTER_PINS: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    spi_master_en_i |=> (pad_o.oe[`PIN_SCLK] && pad_o.oe[`PIN_MOSI] && !pad_o.oe[`PIN_MISO]
      && pad_o.out[`PIN_MOSI] == $past(master_data_out_i)))
    else $error("enabled master not given its pins");

  AST_SLAVE_NONE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (spi_master_en_i && spi_slave_en_i) |=>
      (pad_o.oe[`PIN_SEL] == $past(pin_direction_reg_i[`PIN_SEL]) && periph_o.slave_select_n && !grant_o[2]))
    else $error("denied slave kept part of its pins");

  AST_DEBUG_DENIED: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (debug_en_i && program_enable_i && !spi_master_en_i && !slow_crystal_osc_en_i) |=>
      (grant_o[2] && !grant_o[3] && pad_o.oe[`PIN_AUX] == $past(pin_direction_reg_i[`PIN_AUX])))
    else $error("debug won over flash loading");

  AST_ANALOG_SELECTED: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (comparator_en_i && !slow_crystal_osc_en_i && !adc_reference_select_i) |=>
      pad_o.analog_adc == pin_onehot($past(adc_channel_select_i)))
    else $error("analog switch set on unselected pin");

  AST_ANALOG_PRIO: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (slow_crystal_osc_en_i && low_freq_clock_cfg_i == `LFCLK_CRYSTAL && adc_en_i) |=>
      (pad_o.analog_adc[`PIN_XTAL_A] == 1'b0 && pad_o.analog_xosc[`PIN_XTAL_B]))
    else $error("converter took crystal pin");

  AST_ANALOG_KEEPS: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (adc_en_i && req_en == '0) |=>
      (pad_o.oe == $past(pin_direction_reg_i) && pad_feature_o == $past(pin_feature_reg_i)))
    else $error("analog use altered digital setup");

  AST_SLAVE_TRISTATE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (spi_slave_en_i && !spi_master_en_i && !slow_crystal_osc_en_i) |=>
      (pad_o.oe[`PIN_MISO] == !$past(pad_in_i[`PIN_SEL])))
    else $error("slave data-out driven while unselected");

  AST_TXD_AND: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (req_en == '0 && xosc_ana == '0) |=>
      (pad_o.out[`PIN_SEL] == ($past(port_data_reg_i[`PIN_SEL]) & $past(uart_txd_i))))
    else $error("shared output not ANDed");

  // Idle crossbar hands every pin back to the GPIO registers
  AST_IDLE_GPIO: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (req_en == '0) |=>
      (pad_o.oe == $past(pin_direction_reg_i) && pad_feature_o == $past(pin_feature_reg_i) && grant_o == '0
      && pad_o.out[`PIN_AUX] == $past(port_data_reg_i[`PIN_AUX])))
    else $error("idle pins left GPIO control");

  AST_RXD_FANOUT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !pin_direction_reg_i[`PIN_AUX] |=> (periph_o.uart_rxd == $past(pad_in_i[`PIN_AUX])))
    else $error("receiver not fed from its input pin");

  AST_INPUT_FANOUT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !pin_direction_reg_i[`PIN_MISO] |=>
      (periph_o.timer0_in == $past(pad_in_i[`PIN_MISO]) && port_data_in_o[`PIN_MISO] == $past(pad_in_i[`PIN_MISO])))
    else $error("input level not fanned out to both users");

  AST_OUTPUT_GATED: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    pin_direction_reg_i[`PIN_XTAL_A] |=> (!periph_o.ext_int0 && !port_data_in_o[`PIN_XTAL_A]))
    else $error("output pin leaked into input users");

  // Flash loading borrows the slave pin set; only the master outranks it
  AST_FLASH_LOAD: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !spi_master_en_i |=> (grant_o[`REQ_SLAVE] == $past(spi_slave_en_i || program_enable_i)))
    else $error("flash pin set not tied to programming enable");

  AST_XOSC_LOWAMP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (slow_crystal_osc_en_i && low_freq_clock_cfg_i == `LFCLK_LOW_AMP) |=>
      (pad_o.analog_xosc == `MASK_XOSC_LOWAMP && !grant_o[`REQ_XOSC]))
    else $error("low-amplitude source not on analog pin");

  AST_XOSC_DIGITAL: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (slow_crystal_osc_en_i && low_freq_clock_cfg_i == `LFCLK_DIGITAL) |=>
      (grant_o[`REQ_XOSC] && pad_o.analog_xosc == `MASK_NONE && !pad_o.oe[`PIN_XTAL_B]))
    else $error("digital clock source not granted its pin");

  AST_DENIED_GPIO: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (spi_master_en_i && pwm_en_i && !two_wire_en_i) |=>
      (!grant_o[`REQ_PWM] && pad_o.oe[`PIN_AUX] == $past(pin_direction_reg_i[`PIN_AUX])))
    else $error("denied block kept its free pin");

  AST_CONVERTER_RANGE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (adc_en_i && !adc_reference_select_i && adc_channel_select_i > `ADC_LAST_PIN_CHANNEL) |=>
      (pad_o.analog_adc == `MASK_NONE))
    else $error("channel beyond the pins switched a pad");

  AST_COMPARATOR_REF: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (comparator_en_i && !adc_en_i && !slow_crystal_osc_en_i && adc_reference_select_i
      && adc_channel_select_i > `ADC_LAST_PIN_CHANNEL) |=> (pad_o.analog_adc == pin_onehot({1'b0, ADC_REF_PIN})))
    else $error("comparator ignored converter reference select");

  AST_PWM_PINS: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (pwm_en_i && req_en[`REQ_TWO_WIRE:`REQ_MASTER] == 4'h0) |=>
      (pad_o.oe[`PIN_MOSI] && pad_o.oe[`PIN_AUX] && pad_o.out[`PIN_MOSI] == $past(pulse_out_a_i)
      && pad_o.out[`PIN_AUX] == $past(pulse_out_b_i)))
    else $error("free pulse outputs not on their pins");

  AST_SLAVE_INPUTS: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (spi_slave_en_i && !spi_master_en_i) |=>
      (periph_o.slave_data_in == $past(pad_in_i[`PIN_MOSI])
      && periph_o.slave_serial_clock == $past(pad_in_i[`PIN_SCLK])))
    else $error("slave inputs not taken from their pins");

  // A driven output and an analog tap on one pad must both stand
  AST_ANALOG_COEXIST: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (spi_master_en_i && adc_en_i && !slow_crystal_osc_en_i && !adc_reference_select_i) |=>
      (pad_o.oe[`PIN_MOSI] && pad_o.analog_adc == pin_onehot($past(adc_channel_select_i))))
    else $error("analog tap blocked by digital use");

endmodule // io_crossbar

// ### hdl/io_crossbar_pkg.sv
/*
  Types shared by the pin crossbar and its surroundings.
  Assumes io_crossbar_regs.svh is compiled alongside.
*/
package io_crossbar_pkg;

  typedef logic [2:0] feature_t;

  // Drive of the seven pads
  typedef struct packed {
    logic [6:0] out;
    logic [6:0] oe;
    logic [6:0] analog_adc;
    logic [6:0] analog_xosc;
  } pad_ctrl_t;

  // Pin levels handed to on-chip blocks
  typedef struct packed {
    logic master_data_in;
    logic slave_select_n;
    logic slave_data_in;
    logic slave_serial_clock;
    logic debug_data_in;
    logic debug_mode_select;
    logic debug_test_clock;
    logic two_wire_data;
    logic two_wire_clock;
    logic low_freq_clock;
    logic uart_rxd;
    logic ext_int0;
    logic ext_int1;
    logic timer0_in;
  } periph_in_t;

endpackage

// ### hdl/io_crossbar_regs.svh
/*
  Constants for the pin crossbar: pin count, pin positions, request
  masks, feature codes and clock-source codes.
  Assumes it is included once per compile unit by bare name.
*/
`ifndef IO_CROSSBAR_REGS_SVH
`define IO_CROSSBAR_REGS_SVH

`define XBAR_NUM_PINS 7
`define XBAR_NUM_DIG 6

// Requester index, highest priority first
`define REQ_XOSC 0
`define REQ_MASTER 1
`define REQ_SLAVE 2
`define REQ_DEBUG 3
`define REQ_TWO_WIRE 4
`define REQ_PWM 5

// Pin positions on port zero
`define PIN_XTAL_A 0
`define PIN_XTAL_B 1
`define PIN_SCLK 2
`define PIN_MOSI 3
`define PIN_MISO 4
`define PIN_SEL 5
`define PIN_AUX 6

// Digital request and oscillator analog masks, bit n is pin n
`define MASK_XOSC_DIG 7'h02
`define MASK_MASTER 7'h1C
`define MASK_SLAVE 7'h3C
`define MASK_DEBUG 7'h7C
`define MASK_TWO_WIRE 7'h60
`define MASK_PWM 7'h48
`define MASK_XOSC_XTAL 7'h03
`define MASK_XOSC_LOWAMP 7'h02
`define MASK_NONE 7'h00

// Slow clock source field codes
`define LFCLK_CRYSTAL 3'h0
`define LFCLK_LOW_AMP 3'h3
`define LFCLK_DIGITAL 3'h4

// Pad feature codes
`define FEAT_OUT_NORMAL 3'h0
`define FEAT_OUT_HIGH 3'h1
`define FEAT_IN_NOPULL 3'h2
`define FEAT_IN_PULLUP 3'h3
`define FEAT_IN_PULLDOWN 3'h4
`define FEAT_IN_OFF 3'h5

`define ADC_LAST_PIN_CHANNEL 4'h6

`endif

// ### verification/io_crossbar_pad_world.sv
/*
  Pad-side partner: the outside world on the seven port-zero pins.
  Assumes pad drive from the crossbar and an external drive set by the bench.
*/
`timescale 1ns/1ps
module io_crossbar_pad_world (
  input wire logic clk_sys_i,
  input wire io_crossbar_pkg::pad_ctrl_t pad_i,
  input wire logic [6:0] ext_en_i,
  input wire logic [6:0] ext_val_i,
  output logic [6:0] pad_in_o
);
  logic [6:0] float_r = 7'h55;
  // Undriven pins toggle so a stale level never passes for a drive
  always_ff @(negedge clk_sys_i) begin
    float_r <= ~float_r;
  end
  // Chip drive wins; else external device; else floating pattern
  assign pad_in_o = (pad_i.oe & pad_i.out) | (~pad_i.oe & ext_en_i & ext_val_i) | (~pad_i.oe & ~ext_en_i & float_r);
endmodule // io_crossbar_pad_world

// ### verification/tb_io_crossbar.sv
/*
  Self-checking bench for the pin crossbar with a cycle model in integers.
  Assumes registered outputs one cycle after the sampled inputs.
*/
`timescale 1ns/1ps
module tb_io_crossbar;
  localparam logic [2:0] REF = 3'h2;
  logic clk_sys_i, reset_i, uart_txd_i, slow_crystal_osc_en_i, spi_master_en_i, master_data_out_i;
  logic master_serial_clock_i, spi_slave_en_i, program_enable_i, slave_data_out_i, debug_en_i;
  logic debug_aux_out_i, debug_data_out_i, two_wire_en_i, two_wire_data_out_i, two_wire_data_oe_i;
  logic two_wire_clock_out_i, two_wire_clock_oe_i, pwm_en_i, pulse_out_a_i, pulse_out_b_i;
  logic adc_en_i, comparator_en_i, adc_reference_select_i, valid, f_on, f_ref;
  logic [6:0] port_data_reg_i, pin_direction_reg_i, pad_in_i, port_data_in_o, ext_en, ext_val;
  logic [2:0] low_freq_clock_cfg_i, f_cfg;
  logic [3:0] adc_channel_select_i, f_ch;
  logic [1:0] f_adc;
  io_crossbar_pkg::feature_t [6:0] pin_feature_reg_i, pad_feature_o, e_feat;
  io_crossbar_pkg::pad_ctrl_t pad_o;
  io_crossbar_pkg::periph_in_t periph_o;
  logic [5:0] grant_o, e_gnt;
  logic [6:0] e_oe, e_out, e_msk, e_ana, e_xo, e_own, e_pdi;
  logic [13:0] e_per;
  logic [31:0] seed = 32'h0000_002D;
  int bad_count = 0, n_tests = 0, cyc = 0;
  // Pin sets per requester, highest priority first
  logic [6:0] msk [6] = '{7'h02, 7'h1C, 7'h3C, 7'h7C, 7'h60, 7'h48};

  io_crossbar #(.ADC_REF_PIN(REF)) dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .port_data_reg_i(port_data_reg_i), .pin_direction_reg_i(pin_direction_reg_i),
    .pin_feature_reg_i(pin_feature_reg_i), .pad_in_i(pad_in_i), .uart_txd_i(uart_txd_i),
    .slow_crystal_osc_en_i(slow_crystal_osc_en_i), .low_freq_clock_cfg_i(low_freq_clock_cfg_i),
    .spi_master_en_i(spi_master_en_i), .master_data_out_i(master_data_out_i),
    .master_serial_clock_i(master_serial_clock_i), .spi_slave_en_i(spi_slave_en_i),
    .program_enable_i(program_enable_i), .slave_data_out_i(slave_data_out_i), .debug_en_i(debug_en_i),
    .debug_aux_out_i(debug_aux_out_i), .debug_data_out_i(debug_data_out_i), .two_wire_en_i(two_wire_en_i),
    .two_wire_data_out_i(two_wire_data_out_i), .two_wire_data_oe_i(two_wire_data_oe_i),
    .two_wire_clock_out_i(two_wire_clock_out_i), .two_wire_clock_oe_i(two_wire_clock_oe_i),
    .pwm_en_i(pwm_en_i), .pulse_out_a_i(pulse_out_a_i), .pulse_out_b_i(pulse_out_b_i), .adc_en_i(adc_en_i),
    .comparator_en_i(comparator_en_i), .adc_channel_select_i(adc_channel_select_i),
    .adc_reference_select_i(adc_reference_select_i), .pad_o(pad_o), .pad_feature_o(pad_feature_o),
    .periph_o(periph_o), .port_data_in_o(port_data_in_o), .grant_o(grant_o));
  io_crossbar_pad_world pw (.clk_sys_i(clk_sys_i), .pad_i(pad_o), .ext_en_i(ext_en), .ext_val_i(ext_val),
    .pad_in_o(pad_in_i));

  initial begin
    clk_sys_i = 0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [27:0] seen, input logic [27:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // All inputs at once; UART line mostly idles high
  task automatic apply(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c, input logic [5:0] en);
    {ext_val, ext_en, port_data_reg_i} = {a[27:14], a[6:0]};
    // Pin setup is written before an analog sweep and then left alone
    if (!f_on) pin_direction_reg_i = a[13:7];
    for (int i = 0; i < 7; i++) if (!f_on) pin_feature_reg_i[i] = 3'(b[4*i+:4] % 6);
    {master_data_out_i, master_serial_clock_i, slave_data_out_i, debug_aux_out_i, debug_data_out_i,
     two_wire_data_out_i, two_wire_data_oe_i, two_wire_clock_out_i, two_wire_clock_oe_i, pulse_out_a_i,
     pulse_out_b_i} = c[10:0];
    uart_txd_i = c[11] | c[12];
    program_enable_i = &c[15:13];
    {pwm_en_i, two_wire_en_i, debug_en_i, spi_slave_en_i, spi_master_en_i, slow_crystal_osc_en_i} = en;
    if (f_on) begin
      {comparator_en_i, adc_en_i, adc_reference_select_i, adc_channel_select_i} = {f_adc, f_ref, f_ch};
      low_freq_clock_cfg_i = f_cfg;
    end else begin
      {comparator_en_i, adc_en_i, adc_reference_select_i, adc_channel_select_i} = c[22:16];
      low_freq_clock_cfg_i = (c[24:23] == 2'h0) ? 3'h0 : (c[24] ? 3'h4 : 3'h3);
    end
  endtask

  task automatic put(input logic [5:0] en, input logic [31:0] cmask);
    @(negedge clk_sys_i);
    apply(rnd(), rnd(), rnd() & cmask, en);
  endtask

  // Reference model, evaluated on the inputs the design samples
  always @(posedge clk_sys_i) begin
    logic [6:0] busy;
    logic [5:0] req;
    if (reset_i) valid = 0;
    else begin
      req = {pwm_en_i, two_wire_en_i, debug_en_i, spi_slave_en_i | program_enable_i, spi_master_en_i,
             slow_crystal_osc_en_i && low_freq_clock_cfg_i == 3'h4};
      busy = 7'h00;
      e_own = 7'h00;
      for (int k = 0; k < 6; k++) begin
        e_gnt[k] = req[k] && ((busy & msk[k]) == 7'h00);
        if (req[k]) busy |= msk[k];
        if (e_gnt[k]) e_own |= msk[k];
      end
      e_oe = pin_direction_reg_i;
      e_out = port_data_reg_i & {1'b1, uart_txd_i, 5'h1F};
      if (e_gnt[0]) e_oe[1] = 1'b0;
      if (e_gnt[1]) begin
        e_oe[4:2] = 3'b011;
        e_out[3:2] = {master_data_out_i, master_serial_clock_i};
      end
      if (e_gnt[2]) begin
        e_oe[5:2] = {1'b0, !pad_in_i[5], 2'b00};
        e_out[4] = slave_data_out_i;
      end
      if (e_gnt[3]) begin
        e_oe[6:2] = 5'b11000;
        e_out[6:5] = {debug_aux_out_i, debug_data_out_i};
      end
      if (e_gnt[4]) begin
        e_oe[6:5] = {two_wire_data_oe_i, two_wire_clock_oe_i};
        e_out[6:5] = {two_wire_data_out_i, two_wire_clock_out_i};
      end
      if (e_gnt[5]) begin
        {e_oe[6], e_oe[3]} = 2'b11;
        {e_out[6], e_out[3]} = {pulse_out_b_i, pulse_out_a_i};
      end
      e_msk = e_oe;
      e_xo = 7'h00;
      if (slow_crystal_osc_en_i && low_freq_clock_cfg_i == 3'h0) e_xo = 7'h03;
      if (slow_crystal_osc_en_i && low_freq_clock_cfg_i == 3'h3) e_xo = 7'h02;
      e_ana = 7'h00;
      if (adc_channel_select_i <= 4'h6) e_ana[adc_channel_select_i[2:0]] = 1'b1;
      if (adc_reference_select_i) e_ana[REF] = 1'b1;
      e_ana = (adc_en_i | comparator_en_i) ? (e_ana & ~e_xo) : 7'h00;
      // Inward levels: idle 0, select and two-wire idle 1, shared inputs gated by direction
      e_per = {e_gnt[1] & pad_in_i[4], !e_gnt[2] | pad_in_i[5], e_gnt[2] & pad_in_i[3], e_gnt[2] & pad_in_i[2],
               e_gnt[3] & pad_in_i[4], e_gnt[3] & pad_in_i[3], e_gnt[3] & pad_in_i[2], !e_gnt[4] | pad_in_i[6],
               !e_gnt[4] | pad_in_i[5], e_gnt[0] & pad_in_i[1], pad_in_i[6] | pin_direction_reg_i[6],
               pad_in_i[0] & !pin_direction_reg_i[0], pad_in_i[2] & !pin_direction_reg_i[2],
               pad_in_i[4] & !pin_direction_reg_i[4]};
      e_pdi = pad_in_i & ~pin_direction_reg_i;
      e_feat = pin_feature_reg_i;
      valid = 1;
    end
  end

  // Outputs settled half a cycle after the edge
  always @(negedge clk_sys_i) begin
    if (valid && !reset_i) begin
      check(28'(grant_o), 28'(e_gnt));
      check(28'(pad_o.oe), 28'(e_oe));
      check(28'(pad_o.out & e_msk), 28'(e_out & e_msk));
      check(28'(pad_o.analog_adc), 28'(e_ana));
      check(28'(pad_o.analog_xosc), 28'(e_xo));
      check(28'(periph_o), 28'(e_per));
      check(28'(port_data_in_o), 28'(e_pdi));
      for (int i = 0; i < 7; i++) if (!e_own[i]) check(28'(pad_feature_o[i]), 28'(e_feat[i]));
    end
  end

  // Hang guard
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc > 5000) begin
      bad_count++;
      finish_test();
    end
  end

  initial begin
    reset_i = 1;
    {f_on, f_ref, f_adc, f_ch, f_cfg} = '0;
    apply(0, 0, 0, 6'h00);
    repeat (5) @(negedge clk_sys_i);
    check(pad_o, 28'h0);
    check(28'(pad_feature_o), 28'({7{3'h2}}));
    reset_i = 0;
    repeat (20) put(6'h00, 32'h0FFF);
    $display("test idle done");
    f_on = 1;
    for (int s = 0; s < 3; s++) for (int ch = 0; ch < 16; ch++) begin
      f_cfg = (s == 0) ? 3'h0 : ((s == 1) ? 3'h3 : 3'h4);
      f_ch = 4'(ch);
      f_ref = f_ch[0];
      f_adc = {f_ch[1], !f_ch[1]};
      put(6'h03, 32'hFFFF_FFFF);
    end
    f_on = 0;
    $display("test analog done");
    for (int c = 0; c < 64; c++) repeat (2) put(6'(c), 32'hFFFF_FFFF);
    $display("test priority done");
    repeat (2000) put(6'(rnd()), 32'hFFFF_FFFF);
    $display("test random done");
    @(negedge clk_sys_i);
    reset_i = 1;
    @(negedge clk_sys_i);
    check(pad_o, 28'h0);
    check(28'(grant_o), 28'h0);
    check(28'(pad_feature_o), 28'({7{3'h2}}));
    check(28'({periph_o, port_data_in_o}), 28'({14'h1068, 7'h00}));
    reset_i = 0;
    repeat (10) put(6'(rnd()), 32'hFFFF_FFFF);
    @(negedge clk_sys_i);
    $display("test reset done");
    finish_test();
  end
endmodule // tb_io_crossbar
